/* rtl/psw_config_regs.sv */
// Purpose: switch protect and buck control register bank
// Assumes: subaddressed byte port from the serial slave, one-cycle strobes
// Notes: password unlock comes from the protection logic as a level
`timescale 1ns/1ps
module psw_config_regs
   import psw_pkg::*;
#(
   parameter int BLANK_CYC = PSW_BLANK_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic password_ok,
   input wire logic apply_strobe,
   input wire logic alternate_apply_strobe,
   input wire logic power_fail_low_flag,
   input wire logic [2:0] switch_enable,
   output logic [2:0] switch_on,
   output logic [2:0] switch_discharge,
   output logic buck_one_pulse_skip,
   output logic [5:0] buck_one_voltage_code,
   output logic buck_one_monitor_blank,
   output logic buck_two_pulse_skip,
   output logic [5:0] buck_two_voltage_code,
   output logic buck_two_monitor_blank
);
   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   logic [7:0] sw_cfg, next_sw_cfg;
   logic wr_ok, wr_b1, wr_b2, apply;
   logic [7:0] rd_b1, rd_b2;

   assign wr_ok = reg_wr && password_ok;
   assign wr_b1 = wr_ok && (reg_addr == PSW_ADDR_BUCK1);
   assign wr_b2 = wr_ok && (reg_addr == PSW_ADDR_BUCK2);
   assign apply = apply_strobe || alternate_apply_strobe;

   always_comb begin
      next_sw_cfg = sw_cfg;
      if (wr_ok && reg_addr == PSW_ADDR_SWITCH) begin
         next_sw_cfg = reg_wdata & PSW_MASK_SWITCH;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sw_cfg <= PSW_RST_SWITCH;
      end else begin
         sw_cfg <= next_sw_cfg;
      end
   end

   // ----------------------------------------------------------------
   // buck channels
   // ----------------------------------------------------------------
   psw_buck_channel #(.RESET_VAL(PSW_RST_BUCK1), .BLANK_CYC(BLANK_CYC))
      u_buck_one (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr(wr_b1),
      .wdata(reg_wdata),
      .apply(apply),
      .rdata(rd_b1),
      .pulse_skip_enable(buck_one_pulse_skip),
      .target_code(buck_one_voltage_code),
      .monitor_blank(buck_one_monitor_blank)
   );

   psw_buck_channel #(.RESET_VAL(PSW_RST_BUCK2), .BLANK_CYC(BLANK_CYC))
      u_buck_two (
      .clk_sys(clk_sys),
      .rst(rst),
      .wr(wr_b2),
      .wdata(reg_wdata),
      .apply(apply),
      .rdata(rd_b2),
      .pulse_skip_enable(buck_two_pulse_skip),
      .target_code(buck_two_voltage_code),
      .monitor_blank(buck_two_monitor_blank)
   );

   // ----------------------------------------------------------------
   // switch outputs and read path
   // ----------------------------------------------------------------
   logic [2:0] cutoff, next_on, next_dis;
   logic [7:0] next_rdata;

   always_comb begin
      cutoff = sw_cfg[PSW_CUTOFF_LSB +: 3];
      // fail flag is active low; a set cutoff bit forces the switch off while the flag is low
      next_on = switch_enable & ~(cutoff & {3{~power_fail_low_flag}});
      // discharge only while off, so it never fights a live output
      next_dis = sw_cfg[2:0] & ~next_on;
      next_rdata = 8'h00;
      if (reg_addr == PSW_ADDR_SWITCH) begin
         next_rdata = sw_cfg;
      end else if (reg_addr == PSW_ADDR_BUCK1) begin
         next_rdata = rd_b1;
      end else if (reg_addr == PSW_ADDR_BUCK2) begin
         next_rdata = rd_b2;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         switch_on <= 3'h0;
         switch_discharge <= 3'h0;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         switch_on <= next_on;
         switch_discharge <= next_dis;
         reg_rdata <= reg_rd ? next_rdata : reg_rdata;
         reg_rvalid <= reg_rd;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   locked_write_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      reg_wr && !password_ok && reg_addr == PSW_ADDR_SWITCH
      |=> sw_cfg == $past(sw_cfg))
      else $error("locked write changed switch config");
   switch_cutoff_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !power_fail_low_flag && sw_cfg[5] |=> !switch_on[2])
      else $error("switch three not cut on power fail");
   cutoff_two_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !power_fail_low_flag && sw_cfg[4] |=> !switch_on[1])
      else $error("switch two not cut on power fail");
   cutoff_one_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !power_fail_low_flag && sw_cfg[3] |=> !switch_on[0])
      else $error("switch one not cut on power fail");
   // sampled rst keeps the release edge out: outputs reset there
   fail_clear_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      power_fail_low_flag && !rst |=> switch_on == $past(switch_enable))
      else $error("switch changed without power fail");
   discharge_off_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (switch_discharge & switch_on) == 3'h0)
      else $error("discharge while switch on");
   discharge_set_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !rst |=> switch_discharge == ($past(sw_cfg[2:0]) & ~switch_on))
      else $error("discharge does not follow its bits");
   sw_reserved_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      sw_cfg[7:6] == 2'b00)
      else $error("switch reserved bits set");
   blank_one_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      wr_b1 |=> ##1 buck_one_monitor_blank [*8])
      else $error("buck one not blanked after write");
   blank_two_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      wr_b2 |=> ##1 buck_two_monitor_blank [*8])
      else $error("buck two not blanked after write");
   apply_one_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      apply && !rst |=> buck_one_voltage_code == $past(rd_b1[5:0]))
      else $error("apply did not load buck one code");
   apply_two_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      apply && !rst |=> buck_two_voltage_code == $past(rd_b2[5:0]))
      else $error("apply did not load buck two code");
   mode_one_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      wr_b1 |=> buck_one_pulse_skip == $past(reg_wdata[7]))
      else $error("buck one mode not taken");
   mode_two_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      wr_b2 |=> buck_two_pulse_skip == $past(reg_wdata[7]))
      else $error("buck two mode not taken");

   wr_b1_c: cover property (@(posedge clk_sys) disable iff (rst) wr_b1);
   apply_c: cover property (@(posedge clk_sys) disable iff (rst)
      wr_b2 ##[1:20] apply);
   cut_c: cover property (@(posedge clk_sys) disable iff (rst)
      switch_discharge != 3'h0);
endmodule // psw_config_regs

/* common/psw_pkg.sv */
// Purpose: shared constants for the switch and buck configuration bank
// Assumes: 8-bit subaddressed register port, 25 MHz system clock
// Notes: voltage codes are 6-bit codes; psw_code_mv converts them to millivolts
package psw_pkg;

   localparam logic [7:0] PSW_ADDR_SWITCH = 8'h15;
   localparam logic [7:0] PSW_ADDR_BUCK1 = 8'h16;
   localparam logic [7:0] PSW_ADDR_BUCK2 = 8'h17;

   localparam logic [7:0] PSW_RST_SWITCH = 8'h00;
   localparam logic [7:0] PSW_RST_BUCK1 = 8'h99;
   localparam logic [7:0] PSW_RST_BUCK2 = 8'h8F;

   localparam logic [7:0] PSW_MASK_SWITCH = 8'h3F;
   localparam logic [7:0] PSW_MASK_BUCK = 8'hBF;

   localparam int PSW_CUTOFF_LSB = 3;
   localparam int PSW_MODE_BIT = 7;
   localparam int PSW_CODE_W = 6;

   localparam int PSW_CLK_HZ = 25_000_000;
   localparam int PSW_BLANK_US = 5_000;
   localparam int PSW_BLANK_CYC = PSW_CLK_HZ / 1_000_000 * PSW_BLANK_US;

   localparam int PSW_MV_BASE = 850;
   localparam int PSW_MV_FINE = 10;
   localparam int PSW_MV_COARSE = 25;
   localparam logic [5:0] PSW_CODE_KNEE = 6'h32;

   typedef enum logic [0:0] {
      PSW_BLANK_IDLE = 1'b0,
      PSW_BLANK_RUN = 1'b1
   } psw_blank_t;

   function automatic logic [10:0] psw_code_mv(input logic [5:0] code);
      logic [10:0] mv;
      mv = 11'(PSW_MV_BASE);
      if (code <= PSW_CODE_KNEE) begin
         mv = 11'(PSW_MV_BASE + PSW_MV_FINE * int'(code));
      end else begin
         mv = 11'(PSW_MV_BASE + PSW_MV_FINE * int'(PSW_CODE_KNEE)
            + PSW_MV_COARSE * (int'(code) - int'(PSW_CODE_KNEE)));
      end
      return mv;
   endfunction

endpackage

/* rtl/psw_blank_timer.sv */
// Purpose: blanks over/under-voltage monitoring after a register write
// Assumes: start is a one-cycle pulse
// Notes: a new start restarts the full interval
`timescale 1ns/1ps
module psw_blank_timer
   import psw_pkg::*;
#(
   parameter int BLANK_CYC = PSW_BLANK_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   output logic blanking
);
   psw_blank_t state, next_state;
   logic [22:0] count, next_count;

   always_comb begin
      next_state = state;
      next_count = count;
      if (start) begin
         next_state = PSW_BLANK_RUN;
         next_count = 23'(BLANK_CYC - 1);
      end else begin
         case (state)
            PSW_BLANK_IDLE: begin
               next_count = '0;
            end
            PSW_BLANK_RUN: begin
               if (count == '0) begin
                  next_state = PSW_BLANK_IDLE;
               end else begin
                  next_count = count - 23'h0_001;
               end
            end
            default: next_state = PSW_BLANK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= PSW_BLANK_IDLE;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign blanking = (state == PSW_BLANK_RUN);

   blank_len_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      start |=> blanking && count == 23'(BLANK_CYC - 1))
      else $error("blanking did not start at full length");
endmodule // psw_blank_timer

/* rtl/psw_buck_channel.sv */
// Purpose: one buck converter setting with pending voltage and apply
// Assumes: write and apply strobes are one-cycle pulses
// Notes: mode takes effect at once, voltage only on apply
`timescale 1ns/1ps
module psw_buck_channel
   import psw_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = PSW_RST_BUCK1,
   parameter int BLANK_CYC = PSW_BLANK_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wr,
   input wire logic [7:0] wdata,
   input wire logic apply,
   output logic [7:0] rdata,
   output logic pulse_skip_enable,
   output logic [5:0] target_code,
   output logic monitor_blank
);
   logic [7:0] reg_q, next_reg;
   logic [5:0] active, next_active;
   logic blank;

   always_comb begin
      next_reg = reg_q;
      next_active = active;
      if (wr) begin
         next_reg = wdata & PSW_MASK_BUCK;
      end
      if (apply) begin
         next_active = reg_q[PSW_CODE_W-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_q <= RESET_VAL;
         active <= RESET_VAL[5:0];
         pulse_skip_enable <= RESET_VAL[PSW_MODE_BIT];
         target_code <= RESET_VAL[5:0];
         monitor_blank <= 1'b0;
      end else begin
         reg_q <= next_reg;
         active <= next_active;
         pulse_skip_enable <= next_reg[PSW_MODE_BIT];
         target_code <= next_active;
         monitor_blank <= blank;
      end
   end

   assign rdata = reg_q;

   psw_blank_timer #(.BLANK_CYC(BLANK_CYC)) u_blank (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(wr),
      .blanking(blank)
   );

   hold_pending_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      (wr && !apply) ##1 !apply |=> target_code == $past(target_code))
      else $error("voltage changed without apply");
   reserved_zero_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      rdata[6] == 1'b0)
      else $error("reserved bit set");
endmodule // psw_buck_channel

/* bench/psw_host_model.sv */
// Purpose: host side of the register port: bytes, password, apply pulses
// Assumes: every request is launched by non-blocking assignment at an edge
// Notes: released address and data show the inverse, never the old value
`timescale 1ns/1ps
module psw_host_model (
   input wire logic clk_sys,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic password_ok,
   output logic apply_strobe,
   output logic alternate_apply_strobe
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      password_ok = 1'b0;
      apply_strobe = 1'b0;
      alternate_apply_strobe = 1'b0;
   end
   task automatic set_password(input logic ok);
      @(posedge clk_sys);
      password_ok <= ok;
   endtask
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
         output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         #1;
         if (reg_rvalid === 1'b1) begin
            d = reg_rdata;
            ok = 1'b1;
         end else begin
            @(posedge clk_sys);
         end
      end
   endtask
   // either strobe loads the pending codes of both converters
   task automatic apply(input logic alt);
      @(posedge clk_sys);
      if (alt) begin
         alternate_apply_strobe <= 1'b1;
      end else begin
         apply_strobe <= 1'b1;
      end
      @(posedge clk_sys);
      apply_strobe <= 1'b0;
      alternate_apply_strobe <= 1'b0;
   endtask
endmodule // psw_host_model

/* bench/tb_top.sv */
// Purpose: self-checking bench for the switch and buck register bank
// Assumes: 25 MHz clock, blanking shortened to 20 cycles
// Notes: all register traffic goes through the host model
`timescale 1ns/1ps
module tb_top;
   import psw_pkg::*;
   localparam int BLANK = 20;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic pf_n = 1'b1;
   logic [2:0] sw_en = 3'h0;
   logic wr, rd_s, rvalid, pw, ap, ap_alt, ps1, ps2, bl1, bl2;
   logic [7:0] addr, wdata, rdata;
   logic [2:0] sw_on, sw_dis;
   logic [5:0] code1, code2;
   int failures = 0;
   int checks = 0;
   always #20 clk_sys = ~clk_sys;
   psw_host_model host (.clk_sys(clk_sys), .reg_wr(wr), .reg_rd(rd_s),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .password_ok(pw), .apply_strobe(ap),
      .alternate_apply_strobe(ap_alt));
   psw_config_regs #(.BLANK_CYC(BLANK)) dut (.clk_sys(clk_sys), .rst(rst),
      .reg_wr(wr), .reg_rd(rd_s), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_rvalid(rvalid), .password_ok(pw),
      .apply_strobe(ap), .alternate_apply_strobe(ap_alt),
      .power_fail_low_flag(pf_n), .switch_enable(sw_en),
      .switch_on(sw_on), .switch_discharge(sw_dis),
      .buck_one_pulse_skip(ps1), .buck_one_voltage_code(code1),
      .buck_one_monitor_blank(bl1), .buck_two_pulse_skip(ps2),
      .buck_two_voltage_code(code2), .buck_two_monitor_blank(bl2));
   // ----------------------------------------------------------------
   // shared checks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (failures == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
         input string msg);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.read_byte(a, d, ok);
      if (!ok) begin
         failures++;
         $display("Error %0t: read got no answer", $time);
         stop_test();
      end
      chk(d, exp, "read");
   endtask
   task automatic blank_len(input logic two, output int n);
      n = 0;
      repeat (40) begin
         @(posedge clk_sys);
         #1;
         if ((two ? bl2 : bl1) === 1'b1) n++;
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd(PSW_ADDR_SWITCH, 8'h00);
      rd(PSW_ADDR_BUCK1, 8'h99);
      rd(PSW_ADDR_BUCK2, 8'h8F);
      chk({2'h0, code1}, 8'h19, "code1 reset");
      chk({2'h0, code2}, 8'h0F, "code2 reset");
      chk({6'h00, ps1, ps2}, 8'h03, "mode reset");
   endtask
   task automatic t_protect();
      host.write_byte(PSW_ADDR_SWITCH, 8'h3F);
      host.write_byte(PSW_ADDR_BUCK2, 8'h00);
      rd(PSW_ADDR_SWITCH, 8'h00);
      rd(PSW_ADDR_BUCK2, 8'h8F);
      host.set_password(1'b1);
      host.write_byte(PSW_ADDR_SWITCH, 8'hFF);
      rd(PSW_ADDR_SWITCH, 8'h3F);
      rd(8'h20, 8'h00);
   endtask
   task automatic t_switch();
      logic [7:0] cfg[4] = '{8'h38, 8'h3F, 8'h3F, 8'h15};
      logic [2:0] en[4] = '{3'h7, 3'h7, 3'h5, 3'h3};
      logic pf[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
      // worked out by hand from the bit meanings, one cut bit last
      logic [2:0] e_on[4] = '{3'h0, 3'h0, 3'h5, 3'h1};
      logic [2:0] e_dis[4] = '{3'h0, 3'h7, 3'h2, 3'h4};
      for (int i = 0; i < 4; i++) begin
         host.write_byte(PSW_ADDR_SWITCH, cfg[i]);
         @(posedge clk_sys);
         pf_n <= pf[i];
         sw_en <= en[i];
         repeat (2) @(posedge clk_sys);
         #1;
         chk({5'h00, sw_on}, {5'h00, e_on[i]}, "switch on");
         chk({5'h00, sw_dis}, {5'h00, e_dis[i]}, "dis");
      end
   endtask
   task automatic t_buck_one();
      int n;
      host.write_byte(PSW_ADDR_BUCK1, 8'h60);
      blank_len(1'b0, n);
      chk(8'(n), 8'(BLANK), "blank one");
      rd(PSW_ADDR_BUCK1, 8'h20);
      chk({7'h00, ps1}, 8'h00, "mode one");
      chk({2'h0, code1}, 8'h19, "code1 pending");
      host.apply(1'b0);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({2'h0, code1}, 8'h20, "code1 applied");
   endtask
   task automatic t_buck_two();
      int n;
      host.write_byte(PSW_ADDR_BUCK2, 8'hFF);
      blank_len(1'b1, n);
      chk(8'(n), 8'(BLANK), "blank two");
      rd(PSW_ADDR_BUCK2, 8'hBF);
      chk({7'h00, ps2}, 8'h01, "mode two");
      chk({2'h0, code2}, 8'h0F, "code2 pending");
      host.apply(1'b1);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({2'h0, code2}, 8'h3F, "code2 applied");
      chk({2'h0, code1}, 8'h20, "code1 kept");
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_protect();
      t_switch();
      t_buck_one();
      t_buck_two();
      // a reset in mid-run must bring back every stored default
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      stop_test();
   end
endmodule // tb_top
